// ===== design/pcibc_pkg.sv
// Shared constants and state types of the bus control handshake block
package pcibc_pkg;
  localparam logic [7:0] CMD_REG_OFFSET = 8'h04;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] CMD_WR_MASK = 16'h0144;
  localparam int CMD_MASTER_EN_BIT = 2;
  localparam int CMD_PERR_EN_BIT = 6;
  localparam int CMD_SERR_EN_BIT = 8;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam int STAT_MABORT_BIT = 13;
  localparam int STAT_PERR_BIT = 15;
  localparam logic [2:0] DEVSEL_TIMEOUT_CLKS = 3'h5;

  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_DATA = 3'b010,
    T_TURN = 3'b100
  } pcibc_tstate_t;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_REQ = 4'b0010,
    M_DATA = 4'b0100,
    M_TURN = 4'b1000
  } pcibc_mstate_t;
endpackage

// ===== design/pcibc_regs.sv
// Command and status register pair at configuration dword 04h
module pcibc_regs
  import pcibc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] offset,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  input wire logic set_mabort,
  input wire logic set_perr,
  output logic [15:0] cmd,
  output logic [31:0] rdata_r
);
  logic [15:0] cmd_r;
  logic [15:0] cmd_nxt;
  logic [15:0] stat_r;
  logic [15:0] stat_nxt;
  logic [31:0] rdata_nxt;
  logic hit;

  assign cmd = cmd_r;
  assign hit = (offset == CMD_REG_OFFSET);

  // Byte-lane writes; status bits clear on one, but a new event wins
  always_comb begin
    cmd_nxt = cmd_r;
    stat_nxt = stat_r;
    if (wr_en && hit) begin
      if (be[0]) begin
        cmd_nxt[7:0] = wdata[7:0] & CMD_WR_MASK[7:0];
      end
      if (be[1]) begin
        cmd_nxt[15:8] = wdata[15:8] & CMD_WR_MASK[15:8];
      end
      if (be[3]) begin
        stat_nxt[15:8] = stat_r[15:8] & ~wdata[31:24];
      end
    end
    if (set_mabort) begin
      stat_nxt[STAT_MABORT_BIT] = 1'b1;
    end
    if (set_perr) begin
      stat_nxt[STAT_PERR_BIT] = 1'b1;
    end
    rdata_nxt = hit ? {stat_r, cmd_r} : 32'h00000000; // Unmapped reads as zero
  end

  // Register stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_r <= CMD_RESET;
      stat_r <= STAT_RESET;
      rdata_r <= 32'h00000000;
    end else begin
      cmd_r <= cmd_nxt;
      stat_r <= stat_nxt;
      rdata_r <= rdata_nxt;
    end
  end
endmodule

// ===== design/pcibc_top.sv
// Bus control handshake: target claim, initiator framing, arbitration, errors
// Functional notes
// - As target, assert device select to claim a cycle addressed here, only while the initiator side is idle.
// - As initiator, abort the cycle if no target claims it in time.
// - Initiator drives frame from start while more data phases follow.
// - Frame released marks the last data phase, for both roles.
// - Assert request when an initiator transaction is wanted and the master enable bit of the command register is set.
// - Accept a grant from the arbiter even without own request.
// - Initiator ready and target ready each signal own readiness.
// - A data phase completes only on an edge with both readies asserted.
// - Any other edge is a wait state; the data phase stays open.
// - Drive parity error on mismatch only while its command enable is set.
// - Pulse system error only while its command enable is set.
// - System error may pulse when not the target of the cycle.
// - Card-side address parity error also pulses system error when enabled.
// - Target stop requests the end; initiator honours it.
module pcibc_top
  import pcibc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic FRAME_N_I,
  output logic FRAME_N_O,
  output logic FRAME_OE,
  input wire logic IRDY_N_I,
  output logic IRDY_N_O,
  output logic IRDY_OE,
  input wire logic TRDY_N_I,
  output logic TRDY_N_O,
  output logic TRDY_OE,
  input wire logic DEVSEL_N_I,
  output logic DEVSEL_N_O,
  output logic DEVSEL_OE,
  input wire logic STOP_N_I,
  output logic STOP_N_O,
  output logic STOP_OE,
  input wire logic PERR_N_I,
  output logic PERR_N_O,
  output logic PERR_OE,
  output logic SERR_N_O,
  output logic SERR_OE,
  output logic REQ_N,
  input wire logic GNT_N,
  input wire logic IDSEL,
  input wire logic TGT_MEM_HIT,
  input wire logic TGT_CFG_CMD,
  input wire logic TGT_WRITE,
  input wire logic TGT_READY,
  input wire logic TGT_NO_BURST,
  output logic TGT_XFER,
  input wire logic [7:0] REG_OFFSET,
  input wire logic [31:0] REG_WDATA,
  input wire logic [3:0] REG_BE,
  output logic [31:0] REG_RDATA,
  input wire logic MST_START,
  input wire logic MST_DATA_RDY,
  input wire logic MST_LAST,
  output logic MST_XFER,
  output logic MST_ABORT,
  output logic MST_DONE,
  output logic MST_PARKED,
  input wire logic PAR_MISMATCH,
  input wire logic SYS_ERR,
  input wire logic CB_ADDR_PERR
);
  // Active-high views of the sampled bus lines
  logic frame_a, irdy_a, trdy_a, devsel_a, stop_a, gnt_a;
  assign frame_a = ~FRAME_N_I;
  assign irdy_a = ~IRDY_N_I;
  assign trdy_a = ~TRDY_N_I;
  assign devsel_a = ~DEVSEL_N_I;
  assign stop_a = ~STOP_N_I;
  assign gnt_a = ~GNT_N;

  logic [15:0] cmd;
  logic frame_prev_r, frame_prev_nxt;

  // Target side state
  pcibc_tstate_t t_state_r, t_state_nxt;
  logic t_devsel_nxt, t_trdy_nxt, t_stop_nxt, t_oe_nxt;
  logic t_cfg_r, t_cfg_nxt, t_wr_r, t_wr_nxt;
  logic t_xfer_nxt, t_claim, t_xfer_now, reg_wr;

  // Initiator side state
  pcibc_mstate_t m_state_r, m_state_nxt;
  logic m_frame_nxt, m_irdy_nxt, m_oe_nxt, m_req_nxt;
  logic m_seen_r, m_seen_nxt, m_mab_r, m_mab_nxt;
  logic [2:0] m_cnt_r, m_cnt_nxt;
  logic m_xfer_nxt, m_abort_nxt, m_done_nxt, m_park_nxt, m_xfer_now;
  logic perr_nxt, perr_oe_nxt, serr_nxt;

  // Claim at the first frame edge: memory hit, or config with IDSEL
  assign t_claim = frame_a & ~frame_prev_r & (m_state_r == M_IDLE)
                   & (TGT_MEM_HIT | (TGT_CFG_CMD & IDSEL));
  assign t_xfer_now = irdy_a & ~TRDY_N_O & (t_state_r == T_DATA);
  assign reg_wr = t_xfer_now & t_cfg_r & t_wr_r;
  assign frame_prev_nxt = frame_a;

  // Target next-state logic
  always_comb begin
    t_state_nxt = t_state_r;
    t_devsel_nxt = 1'b0;
    t_trdy_nxt = 1'b0;
    t_stop_nxt = 1'b0;
    t_oe_nxt = 1'b0;
    t_cfg_nxt = t_cfg_r;
    t_wr_nxt = t_wr_r;
    t_xfer_nxt = t_xfer_now;
    case (t_state_r)
      T_IDLE: begin
        if (t_claim) begin
          t_state_nxt = T_DATA;
          t_devsel_nxt = 1'b1;
          t_trdy_nxt = TGT_READY;
          t_oe_nxt = 1'b1;
          t_cfg_nxt = TGT_CFG_CMD;
          t_wr_nxt = TGT_WRITE;
        end
      end
      T_DATA: begin
        t_oe_nxt = 1'b1;
        // Frame already released: this phase is the last one
        if (~frame_a && (t_xfer_now || (~STOP_N_O && irdy_a))) begin
          t_state_nxt = T_TURN; // Lines driven high one clock before release
        end else begin
          t_devsel_nxt = 1'b1;
          // Disconnect after one phase when bursts are not supported
          t_stop_nxt = ~STOP_N_O | (t_xfer_now & frame_a & TGT_NO_BURST);
          // Ready follows TGT_READY each clock, drops once stop is raised
          t_trdy_nxt = TGT_READY & ~t_stop_nxt;
        end
      end
      T_TURN: begin
        t_state_nxt = T_IDLE;
      end
      default: begin
        t_state_nxt = T_IDLE;
      end
    endcase
  end

  // Target registers
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      t_state_r <= T_IDLE;
      DEVSEL_N_O <= 1'b1;
      TRDY_N_O <= 1'b1;
      STOP_N_O <= 1'b1;
      DEVSEL_OE <= 1'b0;
      TRDY_OE <= 1'b0;
      STOP_OE <= 1'b0;
      t_cfg_r <= 1'b0;
      t_wr_r <= 1'b0;
      TGT_XFER <= 1'b0;
      frame_prev_r <= 1'b0;
    end else begin
      t_state_r <= t_state_nxt;
      DEVSEL_N_O <= ~t_devsel_nxt;
      TRDY_N_O <= ~t_trdy_nxt;
      STOP_N_O <= ~t_stop_nxt;
      DEVSEL_OE <= t_oe_nxt;
      TRDY_OE <= t_oe_nxt;
      STOP_OE <= t_oe_nxt;
      t_cfg_r <= t_cfg_nxt;
      t_wr_r <= t_wr_nxt;
      TGT_XFER <= t_xfer_nxt;
      frame_prev_r <= frame_prev_nxt;
    end
  end

  assign m_xfer_now = ~IRDY_N_O & trdy_a & (m_state_r == M_DATA);

  // Initiator next-state logic
  always_comb begin
    m_state_nxt = m_state_r;
    m_frame_nxt = 1'b0;
    m_irdy_nxt = 1'b0;
    m_oe_nxt = 1'b0;
    m_req_nxt = 1'b0;
    m_seen_nxt = m_seen_r;
    m_mab_nxt = 1'b0;
    m_cnt_nxt = m_cnt_r;
    m_xfer_nxt = m_xfer_now;
    m_abort_nxt = 1'b0;
    m_done_nxt = 1'b0;
    // Parked grant is accepted quietly; no cycle is started from it
    m_park_nxt = gnt_a & REQ_N;
    case (m_state_r)
      M_IDLE: begin
        if (MST_START && cmd[CMD_MASTER_EN_BIT]) begin
          m_state_nxt = M_REQ;
          m_req_nxt = 1'b1;
        end
      end
      M_REQ: begin
        m_req_nxt = 1'b1;
        // Start only on grant with the bus idle
        if (gnt_a && ~frame_a && ~irdy_a && (t_state_r == T_IDLE)) begin
          m_state_nxt = M_DATA;
          m_frame_nxt = 1'b1;
          m_oe_nxt = 1'b1;
          m_req_nxt = 1'b0;
          m_seen_nxt = 1'b0;
          m_cnt_nxt = 3'h0;
        end
      end
      M_DATA: begin
        m_oe_nxt = 1'b1;
        m_seen_nxt = m_seen_r | devsel_a;
        if (m_cnt_r != DEVSEL_TIMEOUT_CLKS) begin
          m_cnt_nxt = m_cnt_r + 3'h1;
        end
        if (m_mab_r) begin
          m_state_nxt = M_TURN; // Ready released one clock after frame
          m_abort_nxt = 1'b1;
        end else if (~m_seen_r && ~devsel_a
                     && (m_cnt_r == DEVSEL_TIMEOUT_CLKS - 3'h1)) begin
          m_mab_nxt = 1'b1;
          m_irdy_nxt = 1'b1;
        end else if (FRAME_N_O && (m_xfer_now || stop_a)) begin
          m_state_nxt = M_TURN;
        end else if (stop_a && devsel_a) begin
          m_irdy_nxt = 1'b1;
        end else begin
          // Ready once raised is held until the phase completes
          m_irdy_nxt = (IRDY_N_O || m_xfer_now) ? MST_DATA_RDY : 1'b1;
          m_frame_nxt = ~FRAME_N_O & ~(m_irdy_nxt & MST_LAST);
        end
      end
      M_TURN: begin
        m_state_nxt = M_IDLE;
        m_done_nxt = 1'b1;
      end
      default: begin
        m_state_nxt = M_IDLE;
      end
    endcase
  end

  // Initiator registers
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      m_state_r <= M_IDLE;
      FRAME_N_O <= 1'b1;
      IRDY_N_O <= 1'b1;
      FRAME_OE <= 1'b0;
      IRDY_OE <= 1'b0;
      REQ_N <= 1'b1;
      m_seen_r <= 1'b0;
      m_mab_r <= 1'b0;
      m_cnt_r <= 3'h0;
      MST_XFER <= 1'b0;
      MST_ABORT <= 1'b0;
      MST_DONE <= 1'b0;
      MST_PARKED <= 1'b0;
    end else begin
      m_state_r <= m_state_nxt;
      FRAME_N_O <= ~m_frame_nxt;
      IRDY_N_O <= ~m_irdy_nxt;
      FRAME_OE <= m_oe_nxt;
      IRDY_OE <= m_oe_nxt;
      REQ_N <= ~m_req_nxt;
      m_seen_r <= m_seen_nxt;
      m_mab_r <= m_mab_nxt;
      m_cnt_r <= m_cnt_nxt;
      MST_XFER <= m_xfer_nxt;
      MST_ABORT <= m_abort_nxt;
      MST_DONE <= m_done_nxt;
      MST_PARKED <= m_park_nxt;
    end
  end

  // Error reporting; system error needs no own cycle in progress
  always_comb begin
    perr_nxt = PAR_MISMATCH & cmd[CMD_PERR_EN_BIT];
    perr_oe_nxt = perr_nxt | ~PERR_N_O; // Drive high one clock before release
    serr_nxt = (SYS_ERR | CB_ADDR_PERR) & cmd[CMD_SERR_EN_BIT];
  end

  // Error registers; system error is open drain, driven only low
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PERR_N_O <= 1'b1;
      PERR_OE <= 1'b0;
      SERR_N_O <= 1'b1;
      SERR_OE <= 1'b0;
    end else begin
      PERR_N_O <= ~perr_nxt;
      PERR_OE <= perr_oe_nxt;
      SERR_N_O <= ~serr_nxt;
      SERR_OE <= serr_nxt;
    end
  end

  pcibc_regs u_regs (
    .clk(CLK_SYS),
    .rst(RST),
    .wr_en(reg_wr),
    .offset(REG_OFFSET),
    .wdata(REG_WDATA),
    .be(REG_BE),
    .set_mabort(m_abort_nxt),
    .set_perr(PAR_MISMATCH),
    .cmd(cmd),
    .rdata_r(REG_RDATA)
  );
endmodule

// ===== bench/pcibc_checker.sv
// Bound checker for the bus control handshake ports
module pcibc_checker (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic FRAME_N_I,
  input wire logic FRAME_N_O,
  input wire logic FRAME_OE,
  input wire logic IRDY_N_I,
  input wire logic TRDY_N_I,
  input wire logic TRDY_N_O,
  input wire logic DEVSEL_N_I,
  input wire logic DEVSEL_N_O,
  input wire logic STOP_N_O,
  input wire logic PERR_N_O,
  input wire logic SERR_N_O,
  input wire logic SERR_OE,
  input wire logic REQ_N,
  input wire logic GNT_N,
  input wire logic IDSEL,
  input wire logic TGT_MEM_HIT,
  input wire logic TGT_XFER,
  input wire logic MST_START,
  input wire logic MST_XFER,
  input wire logic MST_ABORT,
  input wire logic PAR_MISMATCH,
  input wire logic SYS_ERR,
  input wire logic CB_ADDR_PERR
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] nd_r;
  logic [4:0] nd_nxt;
  // Clocks of own frame without device select, saturating
  always_comb nd_nxt = (FRAME_OE && DEVSEL_N_I) ? nd_r + {4'h0, nd_r != 5'h1F} : 5'h00;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) nd_r <= 5'h00;
    else nd_r <= nd_nxt;
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Claim needs a framed, decoded cycle
  a_claim_decode: assert property ($fell(DEVSEL_N_O) |-> !$past(FRAME_N_I) &&
    ($past(TGT_MEM_HIT) || $past(IDSEL))) else $error("claim without decode");
  a_tgt_complete: assert property (TGT_XFER |-> !$past(IRDY_N_I) && !$past(TRDY_N_I))
    else $error("target phase without both readies");
  a_mst_complete: assert property (MST_XFER |-> !$past(IRDY_N_I) && !$past(TRDY_N_I))
    else $error("initiator phase without both readies");
  a_last_phase: assert property (TGT_XFER && $past(FRAME_N_I) |-> DEVSEL_N_O)
    else $error("select kept after last phase");
  a_abort_late: assert property (MST_ABORT |-> nd_r >= 5'h05)
    else $error("abort too early");
  a_abort_bound: assert property (nd_r < 5'h10)
    else $error("unclaimed cycle never ended");
  a_req_cause: assert property ($fell(REQ_N) |-> $past(MST_START))
    else $error("request without start");
  a_frame_grant: assert property ($fell(FRAME_N_O) |-> !$past(GNT_N))
    else $error("frame without grant");
  a_stop_claimed: assert property (!STOP_N_O |-> !DEVSEL_N_O && TRDY_N_O)
    else $error("stop outside claim");
  a_perr_cause: assert property (!PERR_N_O |-> $past(PAR_MISMATCH))
    else $error("parity error without mismatch");
  a_serr_cause: assert property (!SERR_N_O |-> SERR_OE &&
    ($past(SYS_ERR) || $past(CB_ADDR_PERR))) else $error("system error without event");
endmodule

bind pcibc_top pcibc_checker u_chk (.*);

// ===== bench/pcibc_peer.sv
// Far-side agent: arbiter with parking and a target that claims
module pcibc_peer (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_n,
  input wire logic park,
  input wire logic claim,
  input wire logic frame_n,
  input wire logic irdy_n,
  output logic gnt_n,
  output logic dev_n,
  output logic trdy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic act;
  logic fp;
  // Released lines read high through pull-ups; one wait state before the first phase, ready then held low
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gnt_n <= 1'b1;
      dev_n <= 1'b1;
      trdy_n <= 1'b1;
      act <= 1'b0;
      fp <= 1'b1;
    end else begin
      fp <= frame_n;
      gnt_n <= req_n & !park;
      if (!act) begin
        if (claim && !frame_n && fp) begin
          act <= 1'b1;
          dev_n <= 1'b0;
        end
      end else if (!irdy_n && !trdy_n && frame_n) begin
        act <= 1'b0;
        dev_n <= 1'b1;
        trdy_n <= 1'b1;
      end else trdy_n <= 1'b0;
    end
  end
endmodule

// ===== bench/pci_bus_control_handshake_test.sv
// Testbench: config cycles, initiator, abort, stop, parking, errors
module pci_bus_control_handshake_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS, RST, FRAME_N_I, FRAME_N_O, FRAME_OE, IRDY_N_I, IRDY_N_O, IRDY_OE;
  logic TRDY_N_I, TRDY_N_O, TRDY_OE, DEVSEL_N_I, DEVSEL_N_O, DEVSEL_OE, STOP_N_I;
  logic STOP_N_O, STOP_OE, PERR_N_I, PERR_N_O, PERR_OE, SERR_N_O, SERR_OE, REQ_N, GNT_N;
  logic IDSEL, TGT_MEM_HIT, TGT_CFG_CMD, TGT_WRITE, TGT_READY, TGT_NO_BURST, TGT_XFER;
  logic MST_START, MST_DATA_RDY, MST_LAST, MST_XFER, MST_ABORT, MST_DONE, MST_PARKED;
  logic PAR_MISMATCH, SYS_ERR, CB_ADDR_PERR, hf, hi, pt, pd, park, claim, cp;
  logic [7:0] REG_OFFSET;
  logic [31:0] REG_WDATA, REG_RDATA;
  logic [3:0] REG_BE;
  logic [2:0] sn;
  int err_total, n_tests, cyc;
  pcibc_top dut (.*);
  pcibc_peer peer (.clk(CLK_SYS), .rst(RST), .req_n(REQ_N), .park(park), .claim(claim),
    .frame_n(FRAME_N_I), .irdy_n(IRDY_N_I), .gnt_n(GNT_N), .dev_n(pd), .trdy_n(pt));
  // Shared lines resolved from drivers; released lines pulled high
  assign FRAME_N_I = FRAME_OE ? FRAME_N_O : hf;
  assign IRDY_N_I = IRDY_OE ? IRDY_N_O : hi;
  assign TRDY_N_I = TRDY_OE ? TRDY_N_O : pt;
  assign DEVSEL_N_I = DEVSEL_OE ? DEVSEL_N_O : pd;
  assign STOP_N_I = STOP_OE ? STOP_N_O : 1'b1;
  assign PERR_N_I = PERR_OE ? PERR_N_O : 1'b1;
  initial begin
    CLK_SYS = 0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  // Completion seen on the bus, and a hang guard
  always @(posedge CLK_SYS) begin
    cp <= !IRDY_N_I && !TRDY_N_I;
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      test_done;
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task test_done;
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Configuration write as a remote initiator; nb keeps frame low for a burst
  task tcyc(input logic sel, input logic nb, input logic [3:0] be, input logic [31:0] d);
    @(negedge CLK_SYS);
    hf = 0;
    IDSEL = sel;
    TGT_CFG_CMD = 1;
    TGT_NO_BURST = nb;
    REG_BE = be;
    REG_WDATA = d;
    TGT_READY = 0;
    @(negedge CLK_SYS);
    hi = 0;
    hf = !nb;
    TGT_READY = 1;
    sn = 0;
    repeat (8) begin
      @(negedge CLK_SYS);
      sn = sn | {!STOP_N_I, TGT_XFER, !DEVSEL_N_I};
      // Ready stays low with frame released until the last phase ends or select drops
      if (hf && (cp || DEVSEL_N_I)) hi = 1;
      if (!STOP_N_I) hf = 1;
    end
    hi = 1;
    IDSEL = 0;
    TGT_CFG_CMD = 0;
    TGT_NO_BURST = 0;
  endtask
  // Own initiator transaction; cl says whether the peer claims it
  task mcyc(input logic cl);
    int i;
    @(negedge CLK_SYS);
    claim = cl;
    MST_START = 1;
    MST_DATA_RDY = 0;
    sn = 0;
    for (i = 0; i < 20 && MST_DONE !== 1'b1; i++) begin
      @(negedge CLK_SYS);
      sn = sn | {MST_ABORT, MST_XFER, !REQ_N};
      if (FRAME_OE) MST_START = 0;
      MST_DATA_RDY = FRAME_OE;
    end
    MST_START = 0;
    claim = 0;
  endtask
  // Parity and system error events; e is the expected pair of levels
  task inj(input logic [1:0] e);
    @(negedge CLK_SYS);
    PAR_MISMATCH = 1;
    SYS_ERR = 1;
    @(negedge CLK_SYS);
    PAR_MISMATCH = 0;
    SYS_ERR = 0;
    CB_ADDR_PERR = 1;
    chk("err", 32'({PERR_N_O, SERR_N_O}), 32'(e));
    @(negedge CLK_SYS);
    CB_ADDR_PERR = 0;
    chk("cb_serr", 32'(SERR_N_O), 32'(e[0]));
  endtask
  initial begin
    {RST, hf, hi, TGT_WRITE, MST_LAST} = 5'h1F;
    {park, claim, IDSEL, TGT_MEM_HIT, TGT_CFG_CMD, TGT_READY, TGT_NO_BURST} = 7'h00;
    {MST_START, MST_DATA_RDY, PAR_MISMATCH, SYS_ERR, CB_ADDR_PERR} = 5'h00;
    {REG_OFFSET, REG_WDATA, REG_BE} = {8'h04, 32'h0, 4'h0};
    repeat (8) @(negedge CLK_SYS);
    RST = 0;
    chk("rst_rd", REG_RDATA, 32'h0);
    tcyc(1, 0, 4'hF, 32'hFFFF_FFFF);
    chk("cfg_sn", 32'(sn), 32'h3);
    chk("cmd_rd", REG_RDATA, 32'h0000_0144);
    tcyc(0, 0, 4'hF, 32'h0);
    chk("nosel_sn", 32'(sn), 32'h0);
    mcyc(1);
    chk("mst_sn", 32'(sn), 32'h3);
    chk("mst_done", 32'(MST_DONE), 32'h1);
    mcyc(0);
    chk("abort_sn", 32'(sn), 32'h5);
    chk("abort_st", REG_RDATA, 32'h2000_0144);
    tcyc(1, 0, 4'h8, 32'h2000_0000);
    chk("w1c_rd", REG_RDATA, 32'h0000_0144);
    inj(2'b00);
    chk("perr_st", REG_RDATA, 32'h8000_0144);
    tcyc(1, 1, 4'h3, 32'h0);
    chk("stop_sn", 32'(sn), 32'h7);
    inj(2'b11);
    mcyc(1);
    chk("off_sn", 32'(sn), 32'h0);
    park = 1;
    repeat (2) @(negedge CLK_SYS);
    chk("parked", 32'(MST_PARKED), 32'h1);
    park = 0;
    REG_OFFSET = 8'h08;
    @(negedge CLK_SYS);
    chk("unmapped", REG_RDATA, 32'h0);
    test_done;
  end
endmodule
